// >>> tscfg_pkg.sv
// constants, field layout and types of the sensor settings block
// assumes a 25 MHz core clock and a single clock domain
package tscfg_pkg;

  // register pointer values and reset values
  localparam logic [7:0]  PTR_TEMP       = 8'h00;
  localparam logic [7:0]  PTR_SETTINGS   = 8'h01;
  localparam logic [7:0]  PTR_RESET      = 8'h00;
  localparam logic [7:0]  SETTINGS_RESET = 8'h00;
  localparam logic [7:0]  RESERVED_LOW   = 8'h00;
  localparam logic [15:0] TEMP_RESET     = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ  = 16'h0000;

  // fixed upper part of the bus address
  localparam logic [3:0]  ADDR_FIXED     = 4'h9;

  // conversion timing
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          T_CONV_9_MS    = 25;
  localparam int          T_CONV_10_MS   = 50;
  localparam int          T_CONV_11_MS   = 100;
  localparam int          T_CONV_12_MS   = 200;
  localparam int          CONV_9_CYC     = T_CONV_9_MS * (CLK_HZ / 1000);
  localparam int          CONV_10_CYC    = T_CONV_10_MS * (CLK_HZ / 1000);
  localparam int          CONV_11_CYC    = T_CONV_11_MS * (CLK_HZ / 1000);
  localparam int          CONV_12_CYC    = T_CONV_12_MS * (CLK_HZ / 1000);
  localparam int          CONV_CNT_W     = 24;

  // left-aligned result masks per resolution
  localparam logic [15:0] MASK_9         = 16'hff80;
  localparam logic [15:0] MASK_10        = 16'hffc0;
  localparam logic [15:0] MASK_11        = 16'hffe0;
  localparam logic [15:0] MASK_12        = 16'hfff0;

  // consecutive faults needed per queue code
  localparam logic [2:0]  FQ_DEPTH_0     = 3'h1;
  localparam logic [2:0]  FQ_DEPTH_1     = 3'h2;
  localparam logic [2:0]  FQ_DEPTH_2     = 3'h4;
  localparam logic [2:0]  FQ_DEPTH_3     = 3'h6;
  localparam logic [2:0]  FQ_MAX         = 3'h6;

  typedef enum logic [1:0] {
    RES_9  = 2'b00,
    RES_10 = 2'b01,
    RES_11 = 2'b10,
    RES_12 = 2'b11
  } tscfg_res_t;

  // settings byte, bit 15 down to bit 8
  typedef struct packed {
    logic       single_shot_trigger;
    tscfg_res_t resolution_select;
    logic [1:0] fault_queue_depth;
    logic       alarm_polarity;
    logic       thermostat_mode_select;
    logic       shutdown_request;
  } tscfg_settings_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_PTR      = 4'b0011,
    ST_PTR_ACK  = 4'b0100,
    ST_WDAT     = 4'b0101,
    ST_WDAT_ACK = 4'b0110,
    ST_TX       = 4'b0111,
    ST_TX_ACK   = 4'b1000,
    ST_WAIT     = 4'b1001
  } tscfg_bus_state_t;

endpackage

// >>> tscfg_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes pins asynchronous to core_clk
module tscfg_pin_sync #(
  parameter int                WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] stable_ff;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] nxt_stable;

  // a bit changes once stages two and three agree
  assign agree      = ~(s2_ff ^ s3_ff);
  assign nxt_stable = (agree & s3_ff) | (~agree & stable_ff);
  assign pin_sync   = stable_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_ff     <= RESET_VAL;
      s2_ff     <= RESET_VAL;
      s3_ff     <= RESET_VAL;
      stable_ff <= RESET_VAL;
    end else begin
      s1_ff     <= pin_in;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      stable_ff <= nxt_stable;
    end
  end

endmodule // tscfg_pin_sync

// >>> tscfg_top.sv
// serial sensor settings register, bus slave and conversion sequencer
// assumes raw_temp and over_limit come from logic on core_clk
// Operation
// - settings 16 bits, low byte reads zero
// - reset clears settings to all zero
// - single shot in shutdown: one conversion
// - single shot ignored when not shut down
// - single shot bit always reads zero
// - resolution field selects 9 to 12 bits
// - conversion time 25/50/100/200 ms by resolution
// - fault queue needs 1/2/4/6 consecutive faults
// - polarity bit sets alarm active level
// - mode bit picks comparator or interrupt
// - shutdown clear means continuous conversions
// - shutdown finishes current conversion first
// - clearing shutdown resumes continuous conversion
// - write: address, pointer 01, data; acked
// - only first data byte loads settings
// - partial byte at stop/start discarded
// - pointer resets to temperature register
// - temperature left aligned, low bits zero
module tscfg_top
  import tscfg_pkg::*;
#(
  parameter int CONV_CYC_9  = tscfg_pkg::CONV_9_CYC,
  parameter int CONV_CYC_10 = tscfg_pkg::CONV_10_CYC,
  parameter int CONV_CYC_11 = tscfg_pkg::CONV_11_CYC,
  parameter int CONV_CYC_12 = tscfg_pkg::CONV_12_CYC
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // serial bus pins
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_n,
  input  wire logic [2:0]                 address_select_pins,
  // converter and limit compare
  input  wire logic [11:0]                raw_temp,
  input  wire logic                       over_limit,
  // alarm and status
  output logic                            alarm_o,
  output logic [15:0]                     temperature_o,
  output tscfg_pkg::tscfg_settings_t      settings_o,
  output logic                            converting_o
);

  import tscfg_pkg::*;

  // synchronised pins
  logic [1:0]            bus_sync;
  logic [2:0]            addr_sync;
  logic                  scl_s;
  logic                  sda_s;

  tscfg_pin_sync #(
    .WIDTH     (2),
    .RESET_VAL (2'h3)
  ) u_bus_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   ({scl_i, sda_i}),
    .pin_sync (bus_sync)
  );

  tscfg_pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h0)
  ) u_addr_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   (address_select_pins),
    .pin_sync (addr_sync)
  );

  assign scl_s = bus_sync[1];
  assign sda_s = bus_sync[0];

  // state registers
  tscfg_bus_state_t      state_ff;
  tscfg_bus_state_t      nxt_state;
  logic                  scl_q_ff;
  logic                  sda_q_ff;
  logic [3:0]            bit_ff;
  logic [3:0]            nxt_bit;
  logic [7:0]            shift_ff;
  logic [7:0]            nxt_shift;
  logic                  oe_n_ff;
  logic                  nxt_oe_n;
  logic                  rw_ff;
  logic                  nxt_rw;
  logic [7:0]            ptr_ff;
  logic [7:0]            nxt_ptr;
  logic                  hi_ff;
  logic                  nxt_hi;
  logic                  first_ff;
  logic                  nxt_first;
  logic [15:0]           word_ff;
  logic [15:0]           nxt_word;
  logic                  cfg_wr;
  logic                  read_start;
  tscfg_settings_t       cfg_ff;
  tscfg_settings_t       nxt_cfg;
  tscfg_settings_t       wr_cfg;
  logic                  active_ff;
  logic                  nxt_active;
  logic [CONV_CNT_W-1:0] cnt_ff;
  logic [CONV_CNT_W-1:0] nxt_cnt;
  logic [15:0]           temp_ff;
  logic [2:0]            fault_ff;
  logic [2:0]            nxt_fault;
  logic                  irq_ff;
  logic                  alert_ff;

  // bus conditions
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_cond;
  logic                  stop_cond;
  logic                  in_rx;
  logic                  byte_done;
  logic                  addr_match;
  logic [7:0]            cfg_bits;
  logic [15:0]           rd_word;
  logic [7:0]            tx_byte;

  assign scl_rise   = scl_s & ~scl_q_ff;
  assign scl_fall   = ~scl_s & scl_q_ff;
  assign start_cond = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_cond  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign in_rx      = (state_ff == ST_ADDR) || (state_ff == ST_PTR) ||
                      (state_ff == ST_WDAT);
  assign byte_done  = in_rx && scl_fall && (bit_ff == 4'h8);
  assign addr_match = (shift_ff[7:1] == {ADDR_FIXED, addr_sync});
  assign cfg_bits   = cfg_ff;
  assign wr_cfg     = tscfg_settings_t'(shift_ff);

  // read data by pointer
  assign rd_word = (ptr_ff == PTR_TEMP) ? temp_ff :
                   (ptr_ff == PTR_SETTINGS) ?
                   {1'b0, cfg_bits[6:0], RESERVED_LOW} :
                   UNMAPPED_READ;
  assign tx_byte = hi_ff ? rd_word[15:8] : word_ff[7:0];

  // serial slave sequencing
  always_comb begin
    nxt_state  = state_ff;
    nxt_bit    = bit_ff;
    nxt_shift  = shift_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_rw     = rw_ff;
    nxt_ptr    = ptr_ff;
    nxt_hi     = hi_ff;
    nxt_first  = first_ff;
    nxt_word   = word_ff;
    cfg_wr     = 1'b0;
    read_start = 1'b0;
    if (start_cond) begin
      nxt_state = ST_ADDR;
      nxt_bit   = 4'h0;
      nxt_oe_n  = 1'b1;
    end else if (stop_cond) begin
      nxt_state = ST_IDLE;
      nxt_oe_n  = 1'b1;
    end else if (in_rx && scl_rise) begin
      nxt_shift = {shift_ff[6:0], sda_s};
      nxt_bit   = bit_ff + 4'h1;
    end else if (byte_done) begin
      nxt_bit = 4'h0;
      unique case (state_ff)
        ST_ADDR: begin
          if (addr_match) begin
            nxt_state  = ST_ADDR_ACK;
            nxt_oe_n   = 1'b0;
            nxt_rw     = shift_ff[0];
            read_start = shift_ff[0];
          end else begin
            nxt_state = ST_WAIT;
          end
        end
        ST_PTR: begin
          nxt_state = ST_PTR_ACK;
          nxt_oe_n  = 1'b0;
          nxt_ptr   = shift_ff;
          nxt_first = 1'b0;
        end
        default: begin
          if (ptr_ff == PTR_SETTINGS) begin
            nxt_state = ST_WDAT_ACK;
            nxt_oe_n  = 1'b0;
            nxt_first = 1'b1;
            cfg_wr    = ~first_ff;
          end else begin
            nxt_state = ST_WAIT;
          end
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_ff)
        ST_ADDR_ACK: begin
          if (rw_ff) begin
            nxt_state = ST_TX;
            nxt_word  = rd_word;
            nxt_shift = tx_byte;
            nxt_oe_n  = tx_byte[7];
            nxt_hi    = 1'b0;
            nxt_bit   = 4'h1;
          end else begin
            nxt_state = ST_PTR;
            nxt_oe_n  = 1'b1;
          end
        end
        ST_PTR_ACK, ST_WDAT_ACK: begin
          nxt_state = ST_WDAT;
          nxt_oe_n  = 1'b1;
        end
        ST_TX: begin
          if (bit_ff == 4'h8) begin
            nxt_state = ST_TX_ACK;
            nxt_oe_n  = 1'b1;
          end else begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_oe_n  = shift_ff[6];
            nxt_bit   = bit_ff + 4'h1;
          end
        end
        ST_TX_ACK: begin
          nxt_state = ST_TX;
          nxt_word  = hi_ff ? rd_word : word_ff;
          nxt_shift = tx_byte;
          nxt_oe_n  = tx_byte[7];
          nxt_hi    = ~hi_ff;
          nxt_bit   = 4'h1;
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end else if (scl_rise && state_ff == ST_TX_ACK && sda_s) begin
      nxt_state = ST_WAIT;
    end
  end

  // conversion sequencing
  logic [CONV_CNT_W-1:0] conv_limit;
  logic                  conv_done;
  logic                  os_accept;
  logic                  os_pending;
  logic [15:0]           res_mask;
  logic [2:0]            fq_depth;
  logic                  fault_met;
  logic                  fault_rise;
  logic                  alarm_active;

  always_comb begin
    unique case (cfg_ff.resolution_select)
      RES_9: begin
        conv_limit = CONV_CNT_W'(CONV_CYC_9 - 1);
        res_mask   = MASK_9;
      end
      RES_10: begin
        conv_limit = CONV_CNT_W'(CONV_CYC_10 - 1);
        res_mask   = MASK_10;
      end
      RES_11: begin
        conv_limit = CONV_CNT_W'(CONV_CYC_11 - 1);
        res_mask   = MASK_11;
      end
      RES_12: begin
        conv_limit = CONV_CNT_W'(CONV_CYC_12 - 1);
        res_mask   = MASK_12;
      end
    endcase
  end

  assign fq_depth = (cfg_ff.fault_queue_depth == 2'b00) ? FQ_DEPTH_0 :
                    (cfg_ff.fault_queue_depth == 2'b01) ? FQ_DEPTH_1 :
                    (cfg_ff.fault_queue_depth == 2'b10) ? FQ_DEPTH_2 :
                    FQ_DEPTH_3;

  assign conv_done  = active_ff && (cnt_ff >= conv_limit);
  assign os_pending = cfg_ff.single_shot_trigger & ~conv_done;
  assign os_accept  = cfg_wr && wr_cfg.single_shot_trigger &&
                      cfg_ff.shutdown_request && !active_ff;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_cfg.single_shot_trigger = os_pending;
    if (cfg_wr) begin
      nxt_cfg = wr_cfg;
      nxt_cfg.single_shot_trigger = os_accept | os_pending;
    end
  end

  always_comb begin
    nxt_active = active_ff;
    nxt_cnt    = cnt_ff + CONV_CNT_W'(1);
    if (conv_done) begin
      nxt_active = ~cfg_ff.shutdown_request;
      nxt_cnt    = '0;
    end else if (!active_ff) begin
      nxt_active = ~cfg_ff.shutdown_request | cfg_ff.single_shot_trigger;
      nxt_cnt    = '0;
    end
  end

  assign nxt_fault    = !conv_done ? fault_ff :
                        !over_limit ? 3'h0 :
                        (fault_ff == FQ_MAX) ? fault_ff :
                        fault_ff + 3'h1;
  assign fault_met    = (fault_ff >= fq_depth);
  assign fault_rise   = conv_done && (nxt_fault >= fq_depth) &&
                        (fault_ff < fq_depth);
  assign alarm_active = cfg_ff.thermostat_mode_select ? irq_ff : fault_met;

  // outputs
  assign sda_o         = 1'b0;
  assign sda_oe_n      = oe_n_ff;
  assign alarm_o       = alert_ff;
  assign temperature_o = temp_ff;
  assign settings_o    = cfg_ff;
  assign converting_o  = active_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      bit_ff   <= 4'h0;
      shift_ff <= 8'h00;
      oe_n_ff  <= 1'b1;
      rw_ff    <= 1'b0;
      ptr_ff   <= PTR_RESET;
      hi_ff    <= 1'b1;
      first_ff <= 1'b0;
      word_ff  <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
      bit_ff   <= nxt_bit;
      shift_ff <= nxt_shift;
      oe_n_ff  <= nxt_oe_n;
      rw_ff    <= nxt_rw;
      ptr_ff   <= nxt_ptr;
      hi_ff    <= nxt_hi;
      first_ff <= nxt_first;
      word_ff  <= nxt_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_ff    <= tscfg_settings_t'(SETTINGS_RESET);
      active_ff <= 1'b0;
      cnt_ff    <= '0;
      temp_ff   <= TEMP_RESET;
      fault_ff  <= 3'h0;
      irq_ff    <= 1'b0;
      alert_ff  <= 1'b1;
    end else begin
      cfg_ff    <= nxt_cfg;
      active_ff <= nxt_active;
      cnt_ff    <= nxt_cnt;
      if (conv_done) begin
        temp_ff <= {raw_temp, 4'h0} & res_mask;
      end
      fault_ff  <= nxt_fault;
      irq_ff    <= fault_rise | (irq_ff & ~read_start);
      alert_ff  <= cfg_ff.alarm_polarity ? alarm_active : ~alarm_active;
    end
  end

endmodule // tscfg_top

// >>> tscfg_checker.sv
// concurrent checks on the settings block top ports
// assumes one clock domain with synchronous active-low reset
module tscfg_checker
  import tscfg_pkg::*;
#(
  parameter int CONV_CYC_9  = 40,
  parameter int CONV_CYC_10 = 80,
  parameter int CONV_CYC_11 = 160,
  parameter int CONV_CYC_12 = 320
) (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  // watched outputs
  input wire logic                       sda_oe_n,
  input wire logic                       alarm_o,
  input wire logic [15:0]                temperature_o,
  input wire tscfg_pkg::tscfg_settings_t settings_o,
  input wire logic                       converting_o
);
  logic [31:0] conv_len;
  logic [31:0] run_cnt_ff;
  logic [31:0] nxt_run_cnt;
  logic        ss_ff;
  logic        nxt_ss;

  // expected conversion length for the current resolution
  assign conv_len = (settings_o.resolution_select == RES_9)  ? 32'(CONV_CYC_9) :
                    (settings_o.resolution_select == RES_10) ? 32'(CONV_CYC_10) :
                    (settings_o.resolution_select == RES_11) ? 32'(CONV_CYC_11) :
                                                               32'(CONV_CYC_12);
  assign nxt_run_cnt = converting_o ? run_cnt_ff + 32'h1 : 32'h0;
  assign nxt_ss = converting_o &&
                  ((run_cnt_ff == 32'h0) ? settings_o.shutdown_request : ss_ff);

  // length of the current conversion run, single-shot flag
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_cnt_ff <= 32'h0;
      ss_ff      <= 1'b0;
    end else begin
      run_cnt_ff <= nxt_run_cnt;
      ss_ff      <= nxt_ss;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_reset_vals;
    $rose(rst_n) |-> settings_o == 8'h00 && temperature_o == 16'h0000 &&
                     sda_oe_n && alarm_o && !converting_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values");

  property p_low_nib;
    temperature_o[3:0] == 4'h0;
  endproperty
  a_low_nib: assert property (p_low_nib) else $error("low bits set");

  property p_conv_time;
    $fell(converting_o) && ss_ff |->
      run_cnt_ff >= conv_len && run_cnt_ff <= conv_len + 32'h2;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conv time");

  property p_ss_clear;
    $fell(converting_o) && ss_ff |-> ##[0:2] !settings_o.single_shot_trigger;
  endproperty
  a_ss_clear: assert property (p_ss_clear) else $error("ss not clear");

  property p_ss_once;
    $fell(converting_o) && ss_ff |=> !converting_o [*8];
  endproperty
  a_ss_once: assert property (p_ss_once) else $error("extra conv");

  property p_ss_ignored;
    settings_o.single_shot_trigger |-> settings_o.shutdown_request;
  endproperty
  a_ss_ignored: assert property (p_ss_ignored) else $error("ss taken");

  property p_cont;
    !settings_o.shutdown_request [*3] |-> converting_o;
  endproperty
  a_cont: assert property (p_cont) else $error("not converting");

  property p_sd_finish;
    $rose(settings_o.shutdown_request) && converting_o && !ss_ff |=> converting_o;
  endproperty
  a_sd_finish: assert property (p_sd_finish) else $error("conv cut");

  property p_pol;
    $changed(settings_o.alarm_polarity) && !settings_o.thermostat_mode_select
      |=> alarm_o != $past(alarm_o);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity");
endmodule // tscfg_checker

bind tscfg_top tscfg_checker #(
  .CONV_CYC_9 (CONV_CYC_9),
  .CONV_CYC_10(CONV_CYC_10),
  .CONV_CYC_11(CONV_CYC_11),
  .CONV_CYC_12(CONV_CYC_12)
) i_chk (
  .core_clk     (core_clk),
  .rst_n        (rst_n),
  .sda_oe_n     (sda_oe_n),
  .alarm_o      (alarm_o),
  .temperature_o(temperature_o),
  .settings_o   (settings_o),
  .converting_o (converting_o)
);

// >>> tscfg_bus_master.sv
// serial bus master model for the settings block
// assumes the bench resolves the open-drain data wire
module tscfg_bus_master (
  // clock
  input  wire logic core_clk,
  // wire levels
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 16;

  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // start or repeated start, leaves scl low
  task automatic start();
    tick(HALF / 2);
    sda_rel <= 1'b1;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_rel <= 1'b0;
    tick(HALF);
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick(HALF / 2);
    sda_rel <= 1'b0;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_rel <= 1'b1;
    tick(HALF);
  endtask

  // one bit: data changes mid low phase, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    tick(HALF / 2);
    sda_rel <= b;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    r = sda_line;
    scl <= 1'b0;
  endtask

  // up to 8 bits, msb first
  task automatic send(input logic [7:0] d, input int n, output logic [7:0] q);
    logic r;
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
  endtask
endmodule // tscfg_bus_master

// >>> tscfg_top_tb.sv
// self-checking bench for the sensor settings block
// assumes the master model and checker are compiled first
module tscfg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tscfg_pkg::*;

  localparam int         C9    = 40;
  localparam int         C10   = 80;
  localparam int         C11   = 160;
  localparam int         C12   = 1200;
  localparam logic [2:0] AAA   = 3'h5;
  localparam logic [7:0] ADR_W = {ADDR_FIXED, AAA, 1'b0};
  localparam logic [7:0] ADR_R = {ADDR_FIXED, AAA, 1'b1};

  logic            core_clk;
  logic            rst_n;
  logic            scl;
  logic            sda_rel;
  logic            sda_line;
  logic            sda_o;
  logic            sda_oe_n;
  logic [11:0]     raw_temp;
  logic            over_limit;
  logic            alarm_o;
  logic [15:0]     temperature_o;
  tscfg_settings_t settings_o;
  logic            converting_o;
  int              n_mismatch;
  int              n_checks;
  logic [15:0]     masks [4];
  int              conv  [4];
  int              depth [4];

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  // open-drain wire with pull-up
  assign sda_line = sda_rel & (sda_oe_n | sda_o);

  tscfg_top #(
    .CONV_CYC_9 (C9),
    .CONV_CYC_10(C10),
    .CONV_CYC_11(C11),
    .CONV_CYC_12(C12)
  ) i_dut (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .scl_i              (scl),
    .sda_i              (sda_line),
    .sda_o              (sda_o),
    .sda_oe_n           (sda_oe_n),
    .address_select_pins(AAA),
    .raw_temp           (raw_temp),
    .over_limit         (over_limit),
    .alarm_o            (alarm_o),
    .temperature_o      (temperature_o),
    .settings_o         (settings_o),
    .converting_o       (converting_o)
  );

  tscfg_bus_master i_mst (
    .core_clk(core_clk),
    .sda_line(sda_line),
    .scl     (scl),
    .sda_rel (sda_rel)
  );

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic put(input logic [7:0] d, input logic exp_ack);
    logic [7:0] q;
    logic       a;
    i_mst.send(d, 8, q);
    i_mst.bit_io(1'b1, a);
    chk("ack", {15'h0, a}, {15'h0, exp_ack});
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input int nx);
    i_mst.start();
    put(ADR_W, 1'b0);
    put(ptr, 1'b0);
    put(d, 1'b0);
    repeat (nx) put(~d, 1'b0);
    i_mst.stop();
  endtask

  task automatic rd2(output logic [15:0] w);
    logic a;
    i_mst.start();
    put(ADR_R, 1'b0);
    i_mst.send(8'hff, 8, w[15:8]);
    i_mst.bit_io(1'b0, a);
    i_mst.send(8'hff, 8, w[7:0]);
    i_mst.bit_io(1'b1, a);
    i_mst.stop();
  endtask

  task automatic wait_conv(input logic lvl);
    int k;
    k = 0;
    while (converting_o !== lvl && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 3000) begin
      n_mismatch++;
      $display("FAIL converting_o expected %b seen %b", lvl, converting_o);
      end_of_test();
    end
  endtask

  initial begin
    logic [15:0] w;
    logic [7:0]  q;
    rst_n      = 1'b0;
    raw_temp   = 12'h123;
    over_limit = 1'b0;
    n_mismatch = 0;
    n_checks   = 0;
    masks      = '{MASK_9, MASK_10, MASK_11, MASK_12};
    conv       = '{C9, C10, C11, C12};
    depth      = '{1, 2, 4, 6};
    cyc(2);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk("settings", {8'h00, settings_o}, 16'h0000);
    chk("temperature", temperature_o, 16'h0000);
    chk("alarm", {15'h0, alarm_o}, 16'h0001);
    cyc(3 * C9);
    rd2(w);
    chk("temp read", w, {12'h123, 4'h0} & MASK_9);
    raw_temp <= 12'hab7;
    for (int r = 0; r < 4; r++) begin
      wr(PTR_SETTINGS, {1'b0, r[1:0], 5'h00}, 0);
      cyc(2 * conv[r] + 4);
      @(negedge core_clk);
      chk("temperature", temperature_o, {12'hab7, 4'h0} & masks[r]);
    end
    wr(PTR_SETTINGS, 8'h7e, 2);
    chk("settings", {8'h00, settings_o}, 16'h007e);
    rd2(w);
    chk("settings read", w, 16'h7e00);
    i_mst.start();
    put({ADDR_FIXED, ~AAA, 1'b0}, 1'b1);
    i_mst.stop();
    i_mst.start();
    put(ADR_W, 1'b0);
    put(PTR_SETTINGS, 1'b0);
    i_mst.send(8'h00, 4, q);
    i_mst.stop();
    chk("settings", {8'h00, settings_o}, 16'h007e);
    wr(PTR_SETTINGS, 8'he0, 0);
    chk("settings", {8'h00, settings_o}, 16'h0060);
    raw_temp <= 12'h5a5;
    wr(PTR_SETTINGS, 8'h61, 0);
    wait_conv(1'b0);
    @(negedge core_clk);
    chk("temperature", temperature_o, 16'h5a50);
    cyc(1);
    raw_temp <= 12'h3c3;
    wr(PTR_SETTINGS, 8'he1, 0);
    rd2(w);
    chk("settings read", w, 16'h6100);
    wait_conv(1'b0);
    @(negedge core_clk);
    chk("temperature", temperature_o, 16'h3c30);
    chk("settings", {8'h00, settings_o}, 16'h0061);
    wr(PTR_SETTINGS, 8'h60, 0);
    cyc(4);
    @(negedge core_clk);
    chk("converting", {15'h0, converting_o}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      over_limit <= 1'b0;
      wr(PTR_SETTINGS, {3'b000, i[1:0], i[0], 2'b00}, 0);
      cyc(2 * C9 + 4);
      over_limit <= 1'b1;
      cyc((depth[i] - 1) * C9 - 2);
      @(negedge core_clk);
      if (depth[i] > 1) begin
        chk("alarm quiet", {15'h0, alarm_o}, {15'h0, ~i[0]});
      end
      cyc(C9 + 6);
      @(negedge core_clk);
      chk("alarm active", {15'h0, alarm_o}, {15'h0, i[0]});
    end
    cyc(1);
    over_limit <= 1'b0;
    wr(PTR_SETTINGS, 8'h02, 0);
    rd2(w);
    chk("settings read", w, 16'h0200);
    chk("alarm idle", {15'h0, alarm_o}, 16'h0001);
    over_limit <= 1'b1;
    cyc(2 * C9);
    over_limit <= 1'b0;
    cyc(3 * C9);
    @(negedge core_clk);
    chk("alarm held", {15'h0, alarm_o}, 16'h0000);
    rd2(w);
    cyc(4);
    @(negedge core_clk);
    chk("alarm cleared", {15'h0, alarm_o}, 16'h0001);
    cyc(1);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk("settings", {8'h00, settings_o}, 16'h0000);
    cyc(3 * C9);
    rd2(w);
    chk("temp read", w, {12'h3c3, 4'h0} & MASK_9);
    end_of_test();
  end
endmodule // tscfg_top_tb
